// [design/ioc_consts.svh]
// Constants for the input conditioning block: timing, offsets and fields.
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

`define CLK_HZ 250000000
`define SAMPLE_HZ 10000
`define SAMPLE_DIV (`CLK_HZ / `SAMPLE_HZ)
`define MS_SAMPLES (`SAMPLE_HZ / 1000)
`define SPEED_HZ 625
`define SPEED_SAMPLES (`SAMPLE_HZ / `SPEED_HZ)
`define AVG_SHIFT 20
`define AVG_RECIP (((1 << `AVG_SHIFT) + `SPEED_HZ / 2) / `SPEED_HZ)

`define DIG_HIGH 16'h0fff
`define CMD_FULL 16'h7fff
`define GAIN_SHIFT 8
`define CMD_SHIFT 15

`define OFS_CTRL 8'h00
`define OFS_MIN 8'h04
`define OFS_CENTER 8'h08
`define OFS_MAX 8'h0c
`define OFS_GAIN 8'h10
`define OFS_SHAPE 8'h14
`define OFS_PMIN 8'h18
`define OFS_LIMIT 8'h1c
`define OFS_ACTION 8'h20
`define OFS_HOME 8'h24
`define OFS_DOUT 8'h28
`define OFS_POS 8'h2c
`define OFS_SPEED 8'h30
`define OFS_STATUS 8'h34
`define OFS_CMD 8'h38

`define RST_MIN 16'h0000
`define RST_CENTER 16'h0800
`define RST_MAX 16'h0fff
`define RST_GAIN 16'h1000

`define ST_OFF 0
`define ST_FWD 2
`define ST_BWD 4
`define ST_ESTOP 6
`define ST_HALT 8

`endif

// [design/ioc_pkg.sv]
// Types shared by the input conditioning block.
package ioc_pkg;
	typedef enum logic [1:0] {
		PIN_DIGITAL = 2'h0,
		PIN_ANALOG = 2'h1,
		PIN_PULSE = 2'h2
	} pin_mode_e;

	typedef enum logic [1:0] {
		SRC_POSITION = 2'h0,
		SRC_PERCENT = 2'h1,
		SRC_SPEED = 2'h2,
		SRC_AVG_SPEED = 2'h3
	} cmd_src_e;

	typedef enum logic [3:0] {
		ACT_NONE = 4'h0,
		ACT_SAFE_HALT = 4'h1,
		ACT_OFF = 4'h2,
		ACT_REVERSE = 4'h3,
		ACT_FWD_LIMIT = 4'h4,
		ACT_BWD_LIMIT = 4'h5,
		ACT_LOAD_HOME = 4'h6,
		ACT_RUN_SCRIPT = 4'h7,
		ACT_STOP_SCRIPT = 4'h8,
		ACT_REWIND_SCRIPT = 4'h9,
		ACT_ESTOP = 4'ha
	} action_e;

	typedef enum logic [3:0] {
		DO_M1_ON = 4'h0,
		DO_M2_ON = 4'h1,
		DO_ANY_ON = 4'h2,
		DO_M1_REV = 4'h3,
		DO_M2_REV = 4'h4,
		DO_ANY_REV = 4'h5,
		DO_OVER_VOLT = 4'h6,
		DO_OVER_TEMP = 4'h7,
		DO_STATUS1 = 4'h8,
		DO_STATUS2 = 4'h9,
		DO_ERROR = 4'ha
	} dout_src_e;
endpackage

// [design/mean_filter.sv]
// Running mean of the most recent 2^N samples, N chosen at run time.
module mean_filter #(
	parameter int W = 16,
	parameter int MAX_N = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] n,
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_data,
	output logic out_valid,
	output logic signed [W-1:0] out_data
);
	localparam int DEPTH = 1 << MAX_N;
	localparam int SW = W + MAX_N;

	logic signed [W-1:0] buf_ff [DEPTH];
	logic [MAX_N-1:0] wr_ff;
	logic signed [SW-1:0] sum_ff;
	logic [3:0] n_last_ff;
	logic [3:0] n_eff;
	logic [MAX_N-1:0] oldest;
	logic signed [SW-1:0] nxt_sum;

	always_comb begin
		n_eff = (n > 4'(MAX_N)) ? 4'(MAX_N) : n;
		oldest = wr_ff - MAX_N'((1 << n_eff) % DEPTH);
		nxt_sum = sum_ff + SW'(in_data) - SW'(buf_ff[oldest]);
	end

	// A change of N restarts the window so the sum never mixes lengths.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) buf_ff[i] <= '0;
			wr_ff <= '0;
			sum_ff <= '0;
			n_last_ff <= 4'h0;
		end else if (n != n_last_ff) begin
			for (int i = 0; i < DEPTH; i++) buf_ff[i] <= '0;
			wr_ff <= '0;
			sum_ff <= '0;
			n_last_ff <= n;
		end else if (in_valid) begin
			buf_ff[wr_ff] <= in_data;
			wr_ff <= wr_ff + 1'b1;
			sum_ff <= nxt_sum;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			out_valid <= in_valid && (n == n_last_ff);
			if (in_valid && (n == n_last_ff))
				out_data <= W'(nxt_sum >>> n_eff);
		end
	end
endmodule

// [design/input_conditioning.sv]
// Input conditioning, limit actions and sinking outputs behind APB.
`include "ioc_consts.svh"

module input_conditioning #(
	parameter int SAMPLE_DIV = `SAMPLE_DIV,
	parameter int NOUT = 4,
	parameter int FILT_MAX_N = 8,
	parameter logic [3:0] DOUT_INVERT_RST = 4'h0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic digital_in_pin,
	input wire logic [11:0] analog_in_pin,
	input wire logic [15:0] pulse_in_pin,
	input wire logic pulse_event,
	input wire logic [1:0] motor_on,
	input wire logic [1:0] motor_rev,
	input wire logic over_voltage,
	input wire logic over_temp,
	input wire logic led_status1,
	input wire logic led_status2,
	input wire logic led_error,
	input wire logic [NOUT-1:0] script_ovr_en,
	input wire logic [NOUT-1:0] script_ovr_val,
	output logic signed [15:0] motor_cmd_1,
	output logic signed [15:0] motor_cmd_2,
	output logic [1:0] motor_max_decel,
	output logic [1:0] motor_safe_halt,
	output logic [1:0] motor_coast,
	output logic [1:0] motor_dir_invert,
	output logic [1:0] enc_load,
	output logic [31:0] enc_load_value,
	output logic script_run,
	output logic script_stop,
	output logic script_rewind,
	output logic estop,
	output logic priority_yield,
	output logic [NOUT-1:0] sinking_output_pin
);
	import ioc_pkg::*;

	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7fff)
			sat16 = 16'sh7fff;
		else if (v < -48'sh7fff)
			sat16 = -16'sh7fff;
		else
			sat16 = v[15:0];
	endfunction

	function automatic logic signed [15:0] cscale(
		input logic signed [15:0] v, input logic [15:0] k);
		cscale = sat16((48'(v) * $signed({32'h0, k})) >>> `CMD_SHIFT);
	endfunction

	// Configuration registers.
	pin_mode_e mode_ff;
	logic [3:0] filt_n_ff;
	cmd_src_e src_ff;
	logic [1:0] ctl_motor_ff;
	logic [15:0] min_ff, center_ff, max_ff;
	logic [15:0] gain_pos_ff, gain_neg_ff;
	logic [15:0] deadband_ff;
	logic signed [4:0] exp_ff;
	logic [15:0] pmin_ff;
	logic [15:0] lim_fwd_ff, lim_rev_ff;
	action_e min_act_ff, max_act_ff;
	logic [15:0] timeout_ff;
	logic [31:0] home_ff;
	logic [4*NOUT-1:0] dsrc_ff;
	logic [NOUT-1:0] dinv_ff;

	// APB decode.
	logic wr_en, setup, mapped;
	logic [31:0] rd_mux;
	logic [31:0] prdata_ff;
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= PIN_DIGITAL;
			filt_n_ff <= 4'h0;
			src_ff <= SRC_POSITION;
			ctl_motor_ff <= 2'h0;
			min_ff <= `RST_MIN;
			center_ff <= `RST_CENTER;
			max_ff <= `RST_MAX;
			gain_pos_ff <= `RST_GAIN;
			gain_neg_ff <= `RST_GAIN;
			deadband_ff <= 16'h0;
			exp_ff <= 5'sh0;
			pmin_ff <= 16'h0;
			lim_fwd_ff <= `CMD_FULL;
			lim_rev_ff <= `CMD_FULL;
			min_act_ff <= ACT_NONE;
			max_act_ff <= ACT_NONE;
			timeout_ff <= 16'h0;
			home_ff <= 32'h0;
			dsrc_ff <= '0;
			dinv_ff <= DOUT_INVERT_RST[NOUT-1:0];
		end else if (wr_en) begin
			if (paddr == `OFS_CTRL) begin
				mode_ff <= pin_mode_e'(pwdata[1:0]);
				filt_n_ff <= pwdata[5:2];
				src_ff <= cmd_src_e'(pwdata[7:6]);
				ctl_motor_ff <= pwdata[9:8];
			end else if (paddr == `OFS_MIN) begin
				min_ff <= pwdata[15:0];
			end else if (paddr == `OFS_CENTER) begin
				center_ff <= pwdata[15:0];
			end else if (paddr == `OFS_MAX) begin
				max_ff <= pwdata[15:0];
			end else if (paddr == `OFS_GAIN) begin
				gain_pos_ff <= pwdata[15:0];
				gain_neg_ff <= pwdata[31:16];
			end else if (paddr == `OFS_SHAPE) begin
				deadband_ff <= pwdata[15:0];
				exp_ff <= pwdata[20:16];
			end else if (paddr == `OFS_PMIN) begin
				pmin_ff <= pwdata[15:0];
			end else if (paddr == `OFS_LIMIT) begin
				lim_fwd_ff <= pwdata[15:0];
				lim_rev_ff <= pwdata[31:16];
			end else if (paddr == `OFS_ACTION) begin
				min_act_ff <= action_e'(pwdata[3:0]);
				max_act_ff <= action_e'(pwdata[7:4]);
				timeout_ff <= pwdata[31:16];
			end else if (paddr == `OFS_HOME) begin
				home_ff <= pwdata;
			end else if (paddr == `OFS_DOUT) begin
				dsrc_ff <= pwdata[4*NOUT-1:0];
				dinv_ff <= pwdata[16+NOUT-1:16];
			end
		end
	end

	// Sample strobe and millisecond tick.
	logic [$clog2(SAMPLE_DIV)-1:0] div_ff;
	logic [3:0] ms_div_ff;
	logic strobe, ms_tick;
	assign strobe = (div_ff == '0);
	assign ms_tick = strobe && (ms_div_ff == 4'(`MS_SAMPLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= '0;
			ms_div_ff <= 4'h0;
		end else begin
			div_ff <= strobe ? $bits(div_ff)'(SAMPLE_DIV - 1) : div_ff - 1'b1;
			if (ms_tick)
				ms_div_ff <= 4'h0;
			else if (strobe)
				ms_div_ff <= ms_div_ff + 4'h1;
		end
	end

	// Raw sample and ranging against the center.
	logic [15:0] raw;
	logic signed [16:0] offs;
	logic signed [15:0] ranged_ff;
	logic rng_valid_ff;
	always_comb begin
		case (mode_ff)
			PIN_DIGITAL: raw = digital_in_pin ? `DIG_HIGH : 16'h0;
			PIN_ANALOG: raw = {4'h0, analog_in_pin};
			default: raw = pulse_in_pin;
		endcase
		offs = $signed({1'b0, raw}) - $signed({1'b0, center_ff});
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ranged_ff <= 16'sh0;
			rng_valid_ff <= 1'b0;
		end else begin
			rng_valid_ff <= strobe;
			if (strobe)
				ranged_ff <= sat16((48'(offs) * $signed({32'h0,
					offs < 0 ? gain_neg_ff : gain_pos_ff})) >>> `GAIN_SHIFT);
		end
	end

	logic flt_valid;
	logic signed [15:0] flt;
	mean_filter #(.W(16), .MAX_N(FILT_MAX_N)) u_filter (
		.clk(pclk),
		.rst_n(presetn),
		.n(filt_n_ff),
		.in_valid(rng_valid_ff),
		.in_data(ranged_ff),
		.out_valid(flt_valid),
		.out_data(flt)
	);

	// Deadband, exponent curve and minimum-power offset on the magnitude.
	logic [15:0] mag, curve, bend, shaped;
	logic [31:0] sq;
	logic [19:0] bprod;
	logic [4:0] emag;
	logic signed [15:0] nxt_position;
	always_comb begin
		mag = flt[15] ? 16'(-flt) : flt;
		sq = 32'(mag) * 32'(mag);
		curve = 16'(sq >> `CMD_SHIFT);
		emag = exp_ff[4] ? 5'(-exp_ff) : exp_ff;
		bprod = 20'(mag - curve) * 20'(emag);
		bend = 16'(bprod >> 4);
		shaped = exp_ff[4] ? mag - bend : mag + bend;
		if (mag <= deadband_ff)
			nxt_position = 16'sh0;
		else
			nxt_position = sat16(48'(shaped) + 48'(pmin_ff));
		if (flt[15])
			nxt_position = -nxt_position;
	end

	logic signed [15:0] position_ff;
	logic pos_valid_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			position_ff <= 16'sh0;
			pos_valid_ff <= 1'b0;
		end else begin
			pos_valid_ff <= flt_valid;
			if (flt_valid)
				position_ff <= nxt_position;
		end
	end

	// Speed: change of position per refresh, and its one-second mean.
	logic [3:0] spd_cnt_ff;
	logic [9:0] avg_cnt_ff;
	logic signed [15:0] last_pos_ff, speed_ff, avg_speed_ff;
	logic signed [31:0] avg_sum_ff;
	logic signed [15:0] nxt_speed;
	logic signed [63:0] avg_prod;
	assign nxt_speed = sat16(48'(position_ff) - 48'(last_pos_ff));
	assign avg_prod = (64'(avg_sum_ff) + 64'(nxt_speed)) * 64'(`AVG_RECIP);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spd_cnt_ff <= 4'h0;
			avg_cnt_ff <= 10'h0;
			last_pos_ff <= 16'sh0;
			speed_ff <= 16'sh0;
			avg_speed_ff <= 16'sh0;
			avg_sum_ff <= 32'sh0;
		end else if (pos_valid_ff) begin
			spd_cnt_ff <= spd_cnt_ff + 4'h1;
			if (spd_cnt_ff == 4'(`SPEED_SAMPLES - 1)) begin
				spd_cnt_ff <= 4'h0;
				last_pos_ff <= position_ff;
				speed_ff <= nxt_speed;
				if (avg_cnt_ff == 10'(`SPEED_HZ - 1)) begin
					avg_cnt_ff <= 10'h0;
					avg_sum_ff <= 32'sh0;
					avg_speed_ff <= sat16(48'(avg_prod >>> `AVG_SHIFT));
				end else begin
					avg_cnt_ff <= avg_cnt_ff + 10'h1;
					avg_sum_ff <= avg_sum_ff + 32'(nxt_speed);
				end
			end
		end
	end

	// Limit detection: an action fires once on entering its region.
	logic at_min, at_max, at_min_ff, at_max_ff, fire;
	action_e act;
	assign at_min = raw <= min_ff;
	assign at_max = raw > max_ff;
	always_comb begin
		fire = 1'b0;
		act = ACT_NONE;
		if (strobe && at_min && !at_min_ff) begin
			fire = 1'b1;
			act = min_act_ff;
		end else if (strobe && at_max && !at_max_ff) begin
			fire = 1'b1;
			act = max_act_ff;
		end
	end

	logic [1:0] off_ff, fwd_ff, bwd_ff, halt_ff, inv_ff;
	logic estop_ff, centered;
	logic [31:0] clr;
	assign clr = (wr_en && paddr == `OFS_STATUS) ? pwdata : 32'h0;
	assign centered = (ranged_ff[15] ? 16'(-ranged_ff) : ranged_ff)
		<= deadband_ff;

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			at_min_ff <= 1'b0;
			at_max_ff <= 1'b0;
			off_ff <= 2'h0;
			fwd_ff <= 2'h0;
			bwd_ff <= 2'h0;
			halt_ff <= 2'h0;
			inv_ff <= 2'h0;
			estop_ff <= 1'b0;
		end else begin
			if (strobe) begin
				at_min_ff <= at_min;
				at_max_ff <= at_max;
			end
			off_ff <= (off_ff & ~clr[`ST_OFF+:2])
				| ((fire && act == ACT_OFF) ? ctl_motor_ff : 2'h0);
			fwd_ff <= (fwd_ff & ~clr[`ST_FWD+:2])
				| ((fire && act == ACT_FWD_LIMIT) ? ctl_motor_ff : 2'h0);
			bwd_ff <= (bwd_ff & ~clr[`ST_BWD+:2])
				| ((fire && act == ACT_BWD_LIMIT) ? ctl_motor_ff : 2'h0);
			estop_ff <= (estop_ff && !clr[`ST_ESTOP])
				|| (fire && act == ACT_ESTOP);
			if (fire && act == ACT_SAFE_HALT)
				halt_ff <= halt_ff | ctl_motor_ff;
			else if (rng_valid_ff && centered)
				halt_ff <= 2'h0;
			if (fire && act == ACT_REVERSE)
				inv_ff <= inv_ff ^ ctl_motor_ff;
		end
	end

	// One-cycle pulses for encoder load and the script engine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_load <= 2'h0;
			enc_load_value <= 32'h0;
			script_run <= 1'b0;
			script_stop <= 1'b0;
			script_rewind <= 1'b0;
		end else begin
			enc_load <= (fire && act == ACT_LOAD_HOME) ? ctl_motor_ff : 2'h0;
			if (fire && act == ACT_LOAD_HOME)
				enc_load_value <= home_ff;
			script_run <= fire && act == ACT_RUN_SCRIPT;
			script_stop <= fire && act == ACT_STOP_SCRIPT;
			script_rewind <= fire && act == ACT_REWIND_SCRIPT;
		end
	end

	assign motor_safe_halt = halt_ff;
	assign motor_coast = off_ff;
	assign motor_dir_invert = inv_ff;
	assign estop = estop_ff;
	assign motor_max_decel = halt_ff | fwd_ff | bwd_ff | {2{estop_ff}};

	// Command selection, scaling and gating per motor.
	logic signed [15:0] src_val, scaled;
	logic signed [15:0] mcmd [2];
	logic signed [15:0] cmd_ff [2];
	always_comb begin
		case (src_ff)
			SRC_POSITION: src_val = position_ff;
			SRC_PERCENT: src_val = ranged_ff;
			SRC_SPEED: src_val = speed_ff;
			default: src_val = avg_speed_ff;
		endcase
		scaled = src_val[15] ? cscale(src_val, lim_rev_ff)
			: cscale(src_val, lim_fwd_ff);
		for (int m = 0; m < 2; m++) begin
			mcmd[m] = ctl_motor_ff[m] ? scaled : 16'sh0;
			if (inv_ff[m])
				mcmd[m] = -mcmd[m];
			if (off_ff[m] || halt_ff[m] || estop_ff)
				mcmd[m] = 16'sh0;
			if (fwd_ff[m] && mcmd[m] > 0)
				mcmd[m] = 16'sh0;
			if (bwd_ff[m] && mcmd[m] < 0)
				mcmd[m] = 16'sh0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff[0] <= 16'sh0;
			cmd_ff[1] <= 16'sh0;
		end else begin
			cmd_ff[0] <= mcmd[0];
			cmd_ff[1] <= mcmd[1];
		end
	end
	assign motor_cmd_1 = cmd_ff[0];
	assign motor_cmd_2 = cmd_ff[1];

	// Priority timeout, counted for pulse inputs; it yields only when they drive a motor.
	logic [15:0] idle_ms_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_ms_ff <= 16'h0;
		else if (pulse_event || mode_ff != PIN_PULSE)
			idle_ms_ff <= 16'h0;
		else if (ms_tick && idle_ms_ff != 16'hffff)
			idle_ms_ff <= idle_ms_ff + 16'h1;
	end
	assign priority_yield = mode_ff == PIN_PULSE && ctl_motor_ff != 2'h0
		&& timeout_ff != 16'h0 && idle_ms_ff >= timeout_ff;

	// Sinking outputs.
	logic [NOUT-1:0] dout_act;
	logic [NOUT-1:0] dout_ff;
	always_comb begin
		for (int i = 0; i < NOUT; i++) begin
			case (dout_src_e'(dsrc_ff[4*i+:4]))
				DO_M1_ON: dout_act[i] = motor_on[0];
				DO_M2_ON: dout_act[i] = motor_on[1];
				DO_ANY_ON: dout_act[i] = |motor_on;
				DO_M1_REV: dout_act[i] = motor_rev[0];
				DO_M2_REV: dout_act[i] = motor_rev[1];
				DO_ANY_REV: dout_act[i] = |motor_rev;
				DO_OVER_VOLT: dout_act[i] = over_voltage;
				DO_OVER_TEMP: dout_act[i] = over_temp;
				DO_STATUS1: dout_act[i] = led_status1;
				DO_STATUS2: dout_act[i] = led_status2;
				DO_ERROR: dout_act[i] = led_error;
				default: dout_act[i] = 1'b0;
			endcase
			if (script_ovr_en[i])
				dout_act[i] = script_ovr_val[i];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dout_ff <= DOUT_INVERT_RST[NOUT-1:0];
		else
			dout_ff <= dout_act ^ dinv_ff;
	end
	assign sinking_output_pin = dout_ff;

	// Read path, captured in the setup phase.
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0;
		if (paddr == `OFS_CTRL)
			rd_mux = {22'h0, ctl_motor_ff, src_ff, filt_n_ff, mode_ff};
		else if (paddr == `OFS_MIN)
			rd_mux = {16'h0, min_ff};
		else if (paddr == `OFS_CENTER)
			rd_mux = {16'h0, center_ff};
		else if (paddr == `OFS_MAX)
			rd_mux = {16'h0, max_ff};
		else if (paddr == `OFS_GAIN)
			rd_mux = {gain_neg_ff, gain_pos_ff};
		else if (paddr == `OFS_SHAPE)
			rd_mux = {11'h0, exp_ff, deadband_ff};
		else if (paddr == `OFS_PMIN)
			rd_mux = {16'h0, pmin_ff};
		else if (paddr == `OFS_LIMIT)
			rd_mux = {lim_rev_ff, lim_fwd_ff};
		else if (paddr == `OFS_ACTION)
			rd_mux = {timeout_ff, 8'h0, max_act_ff, min_act_ff};
		else if (paddr == `OFS_HOME)
			rd_mux = home_ff;
		else if (paddr == `OFS_DOUT)
			rd_mux = 32'({dinv_ff, 16'(dsrc_ff)} );
		else if (paddr == `OFS_POS)
			rd_mux = {ranged_ff, position_ff};
		else if (paddr == `OFS_SPEED)
			rd_mux = {avg_speed_ff, speed_ff};
		else if (paddr == `OFS_STATUS)
			rd_mux = {22'h0, halt_ff, 1'b0, estop_ff, bwd_ff, fwd_ff, off_ff};
		else if (paddr == `OFS_CMD)
			rd_mux = {cmd_ff[1], cmd_ff[0]};
		else
			mapped = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h0;
		else if (setup && !pwrite)
			prdata_ff <= rd_mux;
	end
endmodule

// [verif/ioc_assertions.sv]
// Port-level checks for the input conditioning block.
module ioc_assertions #(
	parameter int NOUT = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NOUT-1:0] script_ovr_en,
	input wire logic [NOUT-1:0] script_ovr_val,
	input wire logic [1:0] motor_max_decel,
	input wire logic [1:0] motor_safe_halt,
	input wire logic [1:0] enc_load,
	input wire logic script_run,
	input wire logic script_stop,
	input wire logic script_rewind,
	input wire logic estop,
	input wire logic [NOUT-1:0] sinking_output_pin
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_fire;
		$rose(script_run || script_stop || script_rewind);
	endsequence
	sequence s_quiet;
		!(script_run || script_stop || script_rewind) [*8];
	endsequence
	AST_PREADY_HIGH: assert property (pready)
		else $error("pready low");
	AST_SLVERR_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	AST_ERR_RDATA: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_SCRIPT_PULSE: assert property (s_fire |=> s_quiet)
		else $error("script pulse too long");
	AST_SCRIPT_ONE: assert property (
		$onehot0({script_run, script_stop, script_rewind}))
		else $error("two script pulses at once");
	AST_ENC_PULSE: assert property (
		|enc_load |=> enc_load == 2'h0)
		else $error("encoder load held");
	AST_ESTOP_DECEL: assert property (
		estop |-> motor_max_decel == 2'h3)
		else $error("halt without full deceleration");
	AST_HALT_DECEL: assert property (
		(motor_safe_halt & ~motor_max_decel) == 2'h0)
		else $error("safe halt without full deceleration");
	AST_SCRIPT_OVR: assert property (
		script_ovr_en[0] |=> sinking_output_pin[0] == $past(script_ovr_val[0]))
		else $error("script override ignored");
endmodule

// [verif/io_source_model.sv]
// Stand-in for the switches, sensors and pulse sources outside the block.
module io_source_model #(
	parameter int HALF = 20
) (
	input wire logic pclk,
	input wire logic dig_lvl,
	input wire logic pwm_en,
	input wire logic [11:0] an_lvl,
	output logic digital_in_pin,
	output logic [11:0] analog_in_pin,
	output logic [15:0] pulse_in_pin,
	output logic pulse_event
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic ph = 1'b0;
	// Toggling every HALF cycles holds the wave at half the sample rate,
	// the fastest square wave the filtered input can follow.
	always @(posedge pclk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			ph <= ~ph;
		end
	end
	assign digital_in_pin = pwm_en ? ph : dig_lvl;
	assign analog_in_pin = an_lvl;
	assign pulse_in_pin = {4'h0, an_lvl};
	// Pulse events ride on the wave, so the priority timer sees a live source.
	assign pulse_event = pwm_en && cnt == 0;
endmodule

// [verif/tb.sv]
// Bench for the conditioning block: APB sequences and port checks.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ioc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic dig_lvl = 1'b0;
	logic pwm_en = 1'b0;
	logic [11:0] an_lvl = 12'h800;
	logic [8:0] stat = 9'h000;
	logic [3:0] script_ovr_en = 4'h0;
	logic [3:0] script_ovr_val = 4'h0;
	logic [31:0] prdata, enc_load_value, rd;
	logic pready, pslverr, err, digital_in_pin, pulse_event;
	logic script_run, script_stop, script_rewind, estop, priority_yield;
	logic signed [15:0] motor_cmd_1, motor_cmd_2;
	logic [11:0] analog_in_pin;
	logic [15:0] pulse_in_pin;
	logic [1:0] enc_load, motor_max_decel, motor_safe_halt;
	logic [1:0] motor_coast, motor_dir_invert;
	logic [3:0] sinking_output_pin;
	int bad_count = 0;
	int samples_checked = 0;
	int n_run = 0, n_stop = 0, n_rew = 0, n_enc = 0, n_all = 0, t_all = 0;
	logic [31:0] shp[5] = '{32'h100, 32'h100, 32'h100, 32'h80100, 32'h180100};
	logic [11:0] av[5] = '{12'h810, 12'h820, 12'h7e0, 12'h820, 12'h820};
	logic [15:0] pv[5] = '{16'h0, 16'h220, 16'hfde0, 16'h31c, 16'h124};
	action_e acts[5] = '{ACT_RUN_SCRIPT, ACT_STOP_SCRIPT, ACT_REWIND_SCRIPT,
		ACT_LOAD_HOME, ACT_ESTOP};
	int sb[11] = '{0, 1, 1, 2, 3, 3, 4, 5, 6, 7, 8};
	io_source_model #(.HALF(20)) src (.pclk, .dig_lvl, .pwm_en, .an_lvl,
		.digital_in_pin, .analog_in_pin, .pulse_in_pin, .pulse_event);
	input_conditioning #(.SAMPLE_DIV(20), .FILT_MAX_N(3),
		.DOUT_INVERT_RST(4'h5)) dut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.digital_in_pin, .analog_in_pin, .pulse_in_pin, .pulse_event,
		.motor_on(stat[1:0]), .motor_rev(stat[3:2]), .over_voltage(stat[4]),
		.over_temp(stat[5]), .led_status1(stat[6]), .led_status2(stat[7]),
		.led_error(stat[8]), .script_ovr_en, .script_ovr_val,
		.motor_cmd_1, .motor_cmd_2, .motor_max_decel, .motor_safe_halt,
		.motor_coast, .motor_dir_invert, .enc_load, .enc_load_value,
		.script_run, .script_stop, .script_rewind, .estop,
		.priority_yield, .sinking_output_pin);
	initial begin
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		n_run <= n_run + int'(script_run === 1'b1);
		n_stop <= n_stop + int'(script_stop === 1'b1);
		n_rew <= n_rew + int'(script_rewind === 1'b1);
		n_enc <= n_enc + int'(enc_load === 2'h1);
		n_all <= n_all + int'((script_run | script_stop | script_rewind |
			(|enc_load)) === 1'b1);
	end
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic smp(input int n);
		repeat (n * 20 + 5) @(posedge pclk);
	endtask
	task automatic step(input logic [11:0] v, input int d);
		an_lvl <= v;
		smp(2);
		t_all += d;
		chk(32'(n_all), 32'(t_all));
	endtask
	task automatic dout(input logic [8:0] s, input logic [3:0] e);
		stat <= s;
		repeat (3) @(posedge pclk);
		chk(32'(sinking_output_pin & 4'h1), 32'(e));
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		chk(32'(sinking_output_pin), 32'h5);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 8'h1c, 0);
		chk(rd, 32'h7fff7fff);
		apb(0, 8'h40, 0);
		chk({rd[30:0], err}, 32'h1);
		dig_lvl <= 1'b1;
		smp(2);
		apb(0, 8'h2c, 0);
		chk(rd, 32'h7ff07ff0);
		dig_lvl <= 1'b0;
		smp(2);
		apb(0, 8'h2c, 0);
		chk(rd, 32'h80018001);
		apb(1, 8'h00, 32'hc);
		pwm_en <= 1'b1;
		smp(20);
		apb(0, 8'h2c, 0);
		chk({16'h0, rd[15:0]}, 32'hfff8);
		pwm_en <= 1'b0;
		apb(1, 8'h00, 32'h1);
		apb(1, 8'h18, 32'h20);
		for (int i = 0; i < 5; i++) begin
			apb(1, 8'h14, shp[i]);
			an_lvl <= av[i];
			smp(2);
			apb(0, 8'h2c, 0);
			chk({16'h0, rd[15:0]}, {16'h0, pv[i]});
		end
		apb(1, 8'h14, 32'h100);
		apb(1, 8'h00, 32'h101);
		apb(1, 8'h04, 32'h100);
		apb(1, 8'h0c, 32'hf00);
		apb(1, 8'h24, 32'h5a5a);
		for (int i = 0; i < 5; i++) begin
			apb(1, 8'h20, {24'h0, acts[i], ACT_RUN_SCRIPT});
			step(12'h101, 0);
			step(12'h100, 1);
			step(12'hf00, 0);
			step(12'hf01, int'(i < 4));
		end
		chk({n_run[7:0], n_stop[7:0], n_rew[7:0], n_enc[7:0]},
			32'h06010101);
		chk(enc_load_value, 32'h5a5a);
		chk({estop, motor_max_decel}, 3'h7);
		apb(1, 8'h34, 32'h40);
		chk(32'(estop), 0);
		apb(1, 8'h20, {24'h0, ACT_SAFE_HALT, ACT_NONE});
		step(12'h800, 0);
		step(12'hf01, 0);
		chk(32'(motor_safe_halt), 1);
		step(12'h800, 0);
		chk(32'(motor_safe_halt), 0);
		apb(1, 8'h1c, 32'h7fff4000);
		apb(1, 8'h20, {24'h0, ACT_FWD_LIMIT, ACT_OFF});
		step(12'h820, 0);
		chk({motor_cmd_2, motor_cmd_1}, 32'h110);
		step(12'hf01, 0);
		chk(32'({motor_max_decel, motor_cmd_1}), 32'h10000);
		step(12'h7e0, 0);
		chk({motor_cmd_2, motor_cmd_1}, 32'hfde0);
		step(12'h100, 0);
		chk(32'({motor_coast, motor_cmd_1}), 32'h10000);
		apb(1, 8'h34, 32'h3f);
		apb(1, 8'h20, {24'h0, ACT_REVERSE, ACT_BWD_LIMIT});
		step(12'h7e0, 0);
		chk({motor_cmd_2, motor_cmd_1}, 32'hfde0);
		step(12'h100, 0);
		chk(32'({motor_max_decel, motor_cmd_1}), 32'h10000);
		step(12'h820, 0);
		chk({motor_cmd_2, motor_cmd_1}, 32'h110);
		step(12'hf01, 0);
		chk(32'({motor_dir_invert, motor_cmd_1}), 32'h10000);
		apb(1, 8'h34, 32'h30);
		smp(1);
		chk(32'({motor_dir_invert, motor_cmd_1}), 32'h1c7e8);
		apb(1, 8'h20, 32'h20000);
		apb(1, 8'h00, 32'h102);
		pwm_en <= 1'b1;
		smp(21);
		chk(32'(priority_yield), 32'h0);
		pwm_en <= 1'b0;
		smp(21);
		chk(32'(priority_yield), 32'h1);
		for (int c = 0; c < 11; c++) begin
			apb(1, 8'h28, 32'(c));
			dout(9'h0, 0);
			dout(9'h1 << sb[c], 1);
		end
		script_ovr_en <= 4'h1;
		script_ovr_val <= 4'h1;
		dout(9'h0, 1);
		script_ovr_en <= 4'h0;
		apb(1, 8'h28, 32'h10007);
		dout(9'h0, 1);
		dout(9'h20, 0);
		results();
	end
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		results();
	end
endmodule
bind input_conditioning ioc_assertions #(.NOUT(NOUT)) chk_u (.pclk,
	.presetn, .psel, .penable, .prdata, .pready, .pslverr, .script_ovr_en,
	.script_ovr_val, .motor_max_decel, .motor_safe_halt, .enc_load,
	.script_run, .script_stop, .script_rewind, .estop, .sinking_output_pin);
